// File: hdl/afs_pkg.sv
// Constants and types of the audio FIFO start and DMA request block
package afs_pkg;
    localparam int AFS_AW = 8;
    localparam int AFS_DW = 32;
    localparam int AFS_PW = 3;
    localparam int AFS_DEPTH = 6;
    // Register offsets
    localparam logic [7:0] AFS_ADDR_CTRL = 8'h90;
    localparam logic [7:0] AFS_ADDR_STAT = 8'h94;
    localparam logic [7:0] AFS_ADDR_CLR = 8'h98;
    localparam logic [7:0] AFS_ADDR_EN = 8'h9c;
    localparam logic [7:0] AFS_ADDR_DMA = 8'h9f;
    localparam logic [2:0][7:0] AFS_ADDR_TX = {8'ha8, 8'ha4, 8'ha0};
    localparam logic [1:0][7:0] AFS_ADDR_RX = {8'hb4, 8'hb0};
    // Control fields: tx resets [2:0], rx resets [4:3], tick period [10:8]
    localparam int AFS_CTRL_W = 11;
    localparam int AFS_CTRL_TXRST = 0;
    localparam int AFS_CTRL_RXRST = 3;
    localparam int AFS_CTRL_PER = 8;
    localparam logic [10:0] AFS_CTRL_RST = 11'h21f;
    // Status bits
    localparam int AFS_ST_W = 6;
    localparam int AFS_ST_RX1 = 0;
    localparam int AFS_ST_TX1 = 4;
    localparam int AFS_ST_TICK = 5;
    // DMA source select bits
    localparam int AFS_DMA_A = 0;
    localparam int AFS_DMA_B = 1;
    localparam logic [1:0] AFS_DMA_RST = 2'h0;

    typedef enum logic [2:0] {
        AFS_TX_RESET = 3'b001,
        AFS_TX_HELD = 3'b010,
        AFS_TX_RUN = 3'b100
    } afs_tx_e;

    typedef struct packed {
        afs_tx_e st;
        logic [2:0] wp;
        logic [2:0] rp;
        logic [2:0] cnt;
        logic pre;
    } afs_txf_s;

    typedef struct packed {
        logic [2:0] wp;
        logic [2:0] rp;
        logic [2:0] cnt;
    } afs_rxf_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } afs_bus_s;

    // Advance a ring pointer with wrap at the last slot
    function automatic logic [2:0] afs_next_ptr(logic [2:0] p, logic [2:0] last);
        afs_next_ptr = (p == last) ? 3'h0 : 3'(p + 3'h1);
    endfunction : afs_next_ptr
endpackage : afs_pkg

// File: hdl/afs_mem.sv
// Sample storage of one audio FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module afs_mem #(
    parameter int W = 32,
    parameter int DEPTH = 6
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic re,
    input wire logic [2:0] raddr,
    input wire logic rzero,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    // Three address bits reach at most eight slots
    if (DEPTH < 1 || DEPTH > 8 || W < 1) begin : g_bad_param
        $error("afs_mem: DEPTH must be 1..8 and W at least 1");
    end

    // Write port, and read port that can return a silent sample
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= rzero ? '0 : mem[raddr];
        end
    end
endmodule : afs_mem
`default_nettype wire

// File: hdl/afs_ctrl.sv
// Audio FIFO start control, FIFO flags, audio tick and DMA request routing
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] Released tx FIFO waits, one sample preset
// [R2] First write starts tx, level adds one
// [R3] Each FIFO stores at most six samples
// [R4] Rx FIFOs leave reset only by software
// [R5] Periodic audio tick interrupt starts processing
// [R6] Software start order: tx, rx, tick
// [R7] Software keeps tick write jitter bounded
// [R8] Request b: rx2 full or tx3 empty
// [R9] Request a: rx2 full or tx3 empty
// [R10] Both requests offered to either channel
// [R11] Source select bits 1:0, reset zero
// [R12] Rx full flags clear on port read
// [R13] Tx empty flags clear on FIFO write
// [R14] Requests follow their condition as levels
module afs_ctrl #(
    parameter int W = afs_pkg::AFS_DW,
    parameter int DEPTH = afs_pkg::AFS_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [2:0] tx_take,
    output logic [2:0] tx_sample_valid,
    output logic [2:0][W-1:0] tx_sample,
    input wire logic [1:0] rx_put,
    input wire logic [1:0][W-1:0] rx_sample,
    input wire logic sample_strobe,
    output logic irq,
    output logic dma_request_a,
    output logic dma_request_b
);
    if (DEPTH < 2 || DEPTH > 7 || W < 1 || W > 32) begin : g_bad_param
        $error("afs_ctrl: DEPTH must be 2..7 and W 1..32");
    end

    localparam logic [2:0] LAST = 3'(DEPTH - 1);
    localparam logic [2:0] FULL = 3'(DEPTH);

    typedef struct packed {
        afs_pkg::afs_txf_s [2:0] tx;
        afs_pkg::afs_rxf_s [1:0] rx;
        logic [afs_pkg::AFS_CTRL_W-1:0] ctrl;
        logic [1:0] dma;
        logic [afs_pkg::AFS_ST_W-1:0] stat;
        logic [afs_pkg::AFS_ST_W-1:0] en;
        logic [2:0] tick_cnt;
        logic [2:0] tvld;
        logic [1:0] rsel;
        logic [31:0] rdata;
    } afs_state_s;

    afs_state_s q;
    afs_state_s d;
    afs_pkg::afs_bus_s bus;

    logic [2:0] tx_we;
    logic [2:0] tx_re;
    logic [2:0] tx_rz;
    logic [2:0][2:0] tx_wa;
    logic [2:0][2:0] tx_ra;
    logic [1:0] rx_we;
    logic [1:0] rx_re;
    logic [1:0] rx_rz;
    logic [1:0][2:0] rx_wa;
    logic [1:0][2:0] rx_ra;
    logic [1:0][W-1:0] rx_rd;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Sample storage, one memory per FIFO
    for (genvar g = 0; g < 3; g++) begin : g_txm
        afs_mem #(.W(W), .DEPTH(DEPTH)) u_mem (
            .clk(clk),
            .we(tx_we[g]),
            .waddr(tx_wa[g]),
            .wdata(bus.wdata[W-1:0]),
            .re(tx_re[g]),
            .raddr(tx_ra[g]),
            .rzero(tx_rz[g]),
            .rdata(tx_sample[g])
        );
    end
    for (genvar g = 0; g < 2; g++) begin : g_rxm
        afs_mem #(.W(W), .DEPTH(DEPTH)) u_mem (
            .clk(clk),
            .we(rx_we[g]),
            .waddr(rx_wa[g]),
            .wdata(rx_sample[g]),
            .re(rx_re[g]),
            .raddr(rx_ra[g]),
            .rzero(rx_rz[g]),
            .rdata(rx_rd[g])
        );
    end

    // Next state of the whole block
    always_comb begin
        logic [afs_pkg::AFS_ST_W-1:0] set;
        logic [afs_pkg::AFS_ST_W-1:0] clr;
        logic push;
        logic pop;
        logic [2:0] per;
        set = '0;
        clr = '0;
        push = 1'b0;
        pop = 1'b0;
        per = 3'h0;
        d = q;
        d.tvld = 3'h0;
        d.rsel = 2'h0;
        tx_we = '0;
        tx_re = '0;
        tx_rz = '0;
        tx_wa = '0;
        tx_ra = '0;
        rx_we = '0;
        rx_re = '0;
        rx_rz = '0;
        rx_wa = '0;
        rx_ra = '0;

        // Register writes; unmapped and read-only offsets are ignored
        if (bus.wr) begin
            case (bus.addr)
                afs_pkg::AFS_ADDR_CTRL: d.ctrl = bus.wdata[afs_pkg::AFS_CTRL_W-1:0];
                afs_pkg::AFS_ADDR_EN: d.en = bus.wdata[afs_pkg::AFS_ST_W-1:0];
                afs_pkg::AFS_ADDR_CLR: clr = bus.wdata[afs_pkg::AFS_ST_W-1:0];
                afs_pkg::AFS_ADDR_DMA: d.dma = bus.wdata[1:0]; // see [R11]
                default: d.dma = d.dma;
            endcase
        end

        // Register reads; receive ports are answered by their memory
        if (bus.rd) begin
            case (bus.addr)
                afs_pkg::AFS_ADDR_CTRL: d.rdata = 32'(q.ctrl);
                afs_pkg::AFS_ADDR_STAT: d.rdata = 32'(q.stat);
                afs_pkg::AFS_ADDR_EN: d.rdata = 32'(q.en);
                afs_pkg::AFS_ADDR_DMA: d.rdata = 32'(q.dma); // see [R11]
                default: d.rdata = 32'h0;
            endcase
        end

        // Transmit FIFOs
        for (int i = 0; i < 3; i++) begin
            push = bus.wr && (bus.addr == afs_pkg::AFS_ADDR_TX[i]);
            pop = 1'b0;
            case (q.tx[i].st)
                afs_pkg::AFS_TX_RESET: begin
                    if (!q.ctrl[afs_pkg::AFS_CTRL_TXRST + i]) begin
                        d.tx[i].st = afs_pkg::AFS_TX_HELD; // see [R1]
                    end
                    push = 1'b0;
                end
                afs_pkg::AFS_TX_HELD: begin
                    if (push) begin
                        d.tx[i].st = afs_pkg::AFS_TX_RUN; // see [R2]
                    end
                end
                afs_pkg::AFS_TX_RUN: begin
                    pop = tx_take[i];
                    if (tx_take[i] && (q.tx[i].cnt <= 3'h1)) begin
                        set[afs_pkg::AFS_ST_TX1 - i] = 1'b1; // drained or underrun
                    end
                end
                default: d.tx[i].st = afs_pkg::AFS_TX_RESET;
            endcase
            if (push) begin
                clr[afs_pkg::AFS_ST_TX1 - i] = 1'b1; // see [R13]
            end
            push = push && (q.tx[i].cnt != FULL); // see [R3]
            tx_we[i] = push;
            tx_wa[i] = q.tx[i].wp;
            tx_re[i] = pop;
            tx_ra[i] = q.tx[i].rp;
            tx_rz[i] = q.tx[i].pre || (q.tx[i].cnt == 3'h0);
            d.tvld[i] = pop;
            pop = pop && (q.tx[i].cnt != 3'h0);
            if (push) begin
                d.tx[i].wp = afs_pkg::afs_next_ptr(q.tx[i].wp, LAST);
            end
            if (pop) begin
                d.tx[i].rp = afs_pkg::afs_next_ptr(q.tx[i].rp, LAST);
                d.tx[i].pre = 1'b0;
            end
            if (push && !pop) begin
                d.tx[i].cnt = 3'(q.tx[i].cnt + 3'h1); // see [R2]
            end else if (pop && !push) begin
                d.tx[i].cnt = 3'(q.tx[i].cnt - 3'h1);
            end
            // Software reset presets one silent sample at the head
            if (q.ctrl[afs_pkg::AFS_CTRL_TXRST + i]) begin
                d.tx[i] = '{st: afs_pkg::AFS_TX_RESET, wp: 3'h1, rp: 3'h0,
                            cnt: 3'h1, pre: 1'b1}; // see [R1]
            end
        end

        // Receive FIFOs
        for (int i = 0; i < 2; i++) begin
            pop = bus.rd && (bus.addr == afs_pkg::AFS_ADDR_RX[i]);
            d.rsel[i] = pop;
            rx_re[i] = pop;
            rx_ra[i] = q.rx[i].rp;
            rx_rz[i] = (q.rx[i].cnt == 3'h0);
            if (pop) begin
                clr[afs_pkg::AFS_ST_RX1 + i] = 1'b1; // see [R12]
            end
            pop = pop && (q.rx[i].cnt != 3'h0);
            push = rx_put[i] && (q.rx[i].cnt != FULL); // see [R3]
            rx_we[i] = push;
            rx_wa[i] = q.rx[i].wp;
            if (push && (q.rx[i].cnt == LAST) && !pop) begin
                set[afs_pkg::AFS_ST_RX1 + i] = 1'b1;
            end
            if (push) begin
                d.rx[i].wp = afs_pkg::afs_next_ptr(q.rx[i].wp, LAST);
            end
            if (pop) begin
                d.rx[i].rp = afs_pkg::afs_next_ptr(q.rx[i].rp, LAST);
            end
            if (push && !pop) begin
                d.rx[i].cnt = 3'(q.rx[i].cnt + 3'h1);
            end else if (pop && !push) begin
                d.rx[i].cnt = 3'(q.rx[i].cnt - 3'h1);
            end
            // No automatic release: held empty until software clears the bit
            if (q.ctrl[afs_pkg::AFS_CTRL_RXRST + i]) begin
                d.rx[i] = '0; // see [R4]
                rx_we[i] = 1'b0;
                set[afs_pkg::AFS_ST_RX1 + i] = 1'b0;
            end
        end

        // Audio tick every programmed number of sample periods
        per = q.ctrl[afs_pkg::AFS_CTRL_PER +: 3];
        if (sample_strobe) begin
            if (3'(q.tick_cnt + 3'h1) >= per) begin
                d.tick_cnt = 3'h0;
                set[afs_pkg::AFS_ST_TICK] = 1'b1; // see [R5]
            end else begin
                d.tick_cnt = 3'(q.tick_cnt + 3'h1);
            end
        end

        // Sticky status, a set in the clearing cycle wins
        d.stat = (q.stat & ~clr) | set;
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{tx: {3{afs_pkg::afs_txf_s'{st: afs_pkg::AFS_TX_RESET, wp: 3'h1,
                        rp: 3'h0, cnt: 3'h1, pre: 1'b1}}},
                   rx: '0, ctrl: afs_pkg::AFS_CTRL_RST, dma: afs_pkg::AFS_DMA_RST,
                   stat: '0, en: '0, tick_cnt: 3'h0, tvld: 3'h0, rsel: 2'h0,
                   rdata: 32'h0};
        end else begin
            q <= d;
        end
    end

    // Read data, sample strobes and interrupt
    assign reg_rdata = q.rsel[0] ? 32'(rx_rd[0]) : (q.rsel[1] ? 32'(rx_rd[1]) : q.rdata);
    assign tx_sample_valid = q.tvld;
    assign irq = |(q.stat & q.en);

    // DMA requests as levels, free for either DMA channel
    assign dma_request_b = q.dma[afs_pkg::AFS_DMA_B]
        ? (q.tx[2].st == afs_pkg::AFS_TX_RUN && q.tx[2].cnt == 3'h0)
        : (q.rx[1].cnt == FULL); // see [R8] see [R14] see [R10]
    assign dma_request_a = q.dma[afs_pkg::AFS_DMA_A]
        ? (q.tx[2].st == afs_pkg::AFS_TX_RUN && q.tx[2].cnt == 3'h0)
        : (q.rx[1].cnt == FULL); // see [R9] see [R14] see [R10]
endmodule : afs_ctrl
`default_nettype wire

// File: tb/afs_checker.sv
// Port checker for the audio FIFO start and DMA request block
`timescale 1ns/1ps
`default_nettype none
module afs_checker #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0] tx_take,
    input wire logic [2:0] tx_sample_valid,
    input wire logic [2:0][W-1:0] tx_sample,
    input wire logic [1:0] rx_put,
    input wire logic [1:0][W-1:0] rx_sample,
    input wire logic sample_strobe,
    input wire logic irq,
    input wire logic dma_request_a,
    input wire logic dma_request_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic ev;
    // Any input event that may move a flag or a request
    assign ev = reg_wr | reg_rd | (|tx_take) | (|rx_put) | sample_strobe;
    AST_DMA_RST: assert property ($fell(rst) |-> !dma_request_a && !dma_request_b)
        else $error("request high after reset");
    AST_DMA_RDBK: assert property ((reg_wr && reg_addr == afs_pkg::AFS_ADDR_DMA ##1
        reg_rd && reg_addr == afs_pkg::AFS_ADDR_DMA)
        |=> reg_rdata == {30'h0, $past(reg_wdata[1:0], 2)})
        else $error("source select readback wrong");
    AST_UNMAP: assert property (reg_rd && reg_addr == 8'h80 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_TXV: assert property (|tx_sample_valid |-> (tx_sample_valid & ~$past(tx_take)) == 3'h0)
        else $error("sample valid without take");
    AST_IRQ: assert property ($rose(irq) |-> $past(ev))
        else $error("interrupt rose without cause");
    AST_DMA_A: assert property ($changed(dma_request_a) |-> $past(ev))
        else $error("request a moved without cause");
    AST_DMA_B: assert property ($changed(dma_request_b) |-> $past(ev))
        else $error("request b moved without cause");
    AST_TX3_FILL: assert property (reg_wr && reg_addr == afs_pkg::AFS_ADDR_TX[2] &&
        !rx_put[1] |=> !$rose(dma_request_a) && !$rose(dma_request_b))
        else $error("request rose after transmit write");
endmodule : afs_checker
bind afs_ctrl afs_checker #(.W(W)) afs_checker_inst (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .tx_take, .tx_sample_valid, .tx_sample, .rx_put,
    .rx_sample, .sample_strobe, .irq, .dma_request_a, .dma_request_b);
`default_nettype wire

// File: tb/afs_serial_model.sv
// Serializer side model: takes and delivers samples and beats the word clock
`timescale 1ns/1ps
`default_nettype none
module afs_serial_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] take_go,
    input wire logic [1:0] put_go,
    input wire logic tick_go,
    output logic [2:0] tx_take,
    output logic [1:0] rx_put,
    output logic [1:0][31:0] rx_sample,
    output logic sample_strobe
);
    logic [31:0] seq_q;
    // Each go pulse becomes one transfer; samples are numbered in order
    always_ff @(posedge clk) begin
        if (rst) begin
            seq_q <= 32'h0;
        end else if (|put_go) begin
            seq_q <= seq_q + 32'h1;
        end
        tx_take <= rst ? 3'h0 : take_go;
        rx_put <= rst ? 2'h0 : put_go;
        sample_strobe <= rst ? 1'b0 : tick_go;
    end
    // Data lines carry the inverse of the sample outside a delivery
    assign rx_sample = (|rx_put) ? {2{seq_q}} : {2{~seq_q}};
endmodule : afs_serial_model
`default_nettype wire

// File: tb/test_audio_fifo_start_and_dma_request.sv
// Self-checking bench for the audio FIFO start and DMA request block
`timescale 1ns/1ps
`default_nettype none
module test_audio_fifo_start_and_dma_request;
    logic clk;
    logic rst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [2:0] tx_take;
    logic [2:0] tx_sample_valid;
    logic [2:0][31:0] tx_sample;
    logic [1:0] rx_put;
    logic [1:0][31:0] rx_sample;
    logic sample_strobe;
    logic irq;
    logic dma_request_a;
    logic dma_request_b;
    logic [2:0] take_go;
    logic [1:0] put_go;
    logic tick_go;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int i;
    afs_ctrl afs_ctrl_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .tx_take, .tx_sample_valid, .tx_sample, .rx_put, .rx_sample, .sample_strobe, .irq,
        .dma_request_a, .dma_request_b);
    afs_serial_model afs_serial_model_inst (.clk, .rst, .take_go, .put_go, .tick_go,
        .tx_take, .rx_put, .rx_sample, .sample_strobe);
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // Write then read the same offset with no idle cycle between the strobes
    task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : wrd
    task automatic go(input logic [2:0] t, input logic [1:0] p, input logic s);
        @(posedge clk);
        take_go <= t;
        put_go <= p;
        tick_go <= s;
        @(posedge clk);
        take_go <= 3'h0;
        put_go <= 2'h0;
        tick_go <= 1'b0;
    endtask : go
    // One take from the third transmit FIFO, then its answer
    task automatic tk(input logic v, input logic [31:0] e);
        go(3'h4, 2'h0, 1'b0);
        @(posedge clk);
        #1 chk(32'(tx_sample_valid), v ? 32'h4 : 32'h0);
        if (v) begin
            chk(tx_sample[2], e);
        end
    endtask : tk
    // Levels as {irq, request b, request a} once settled
    task automatic lv(input logic [2:0] e);
        repeat (2) @(posedge clk);
        #1 chk(32'({irq, dma_request_b, dma_request_a}), 32'(e));
    endtask : lv
    // Main sequence
    initial begin
        rst = 1'b1;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        take_go = 3'h0;
        put_go = 2'h0;
        tick_go = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(afs_pkg::AFS_ADDR_CTRL, 32'h21f);
        rd(afs_pkg::AFS_ADDR_DMA, 32'h0);
        rd(8'h80, 32'h0);
        $display("test reset done");
        go(3'h0, 2'h2, 1'b0);
        wr(afs_pkg::AFS_ADDR_CTRL, 32'h207);
        for (i = 0; i < 7; i++) go(3'h0, 2'h2, 1'b0);
        rd(afs_pkg::AFS_ADDR_STAT, 32'h2);
        for (i = 0; i < 4; i++) begin
            wrd(afs_pkg::AFS_ADDR_DMA, 32'(i), 32'(i));
            lv({1'b0, ~i[1], ~i[0]});
        end
        wr(afs_pkg::AFS_ADDR_DMA, 32'h0);
        for (i = 0; i < 7; i++) rd(afs_pkg::AFS_ADDR_RX[1], (i < 6) ? 32'(i + 2) : 32'h0);
        lv(3'h0);
        rd(afs_pkg::AFS_ADDR_STAT, 32'h0);
        $display("test receive done");
        wr(afs_pkg::AFS_ADDR_CTRL, 32'h200);
        tk(1'b0, 32'h0);
        wr(afs_pkg::AFS_ADDR_TX[2], 32'h11);
        wr(afs_pkg::AFS_ADDR_TX[2], 32'h22);
        tk(1'b1, 32'h0);
        tk(1'b1, 32'h11);
        tk(1'b1, 32'h22);
        rd(afs_pkg::AFS_ADDR_STAT, 32'h4);
        wr(afs_pkg::AFS_ADDR_DMA, 32'h1);
        wr(afs_pkg::AFS_ADDR_EN, 32'h24);
        lv(3'h5);
        wr(afs_pkg::AFS_ADDR_TX[2], 32'h33);
        lv(3'h0);
        $display("test transmit done");
        go(3'h0, 2'h0, 1'b1);
        go(3'h0, 2'h0, 1'b1);
        lv(3'h4);
        rd(afs_pkg::AFS_ADDR_STAT, 32'h20);
        wr(afs_pkg::AFS_ADDR_EN, 32'h0);
        lv(3'h0);
        wr(afs_pkg::AFS_ADDR_CLR, 32'h20);
        rd(afs_pkg::AFS_ADDR_STAT, 32'h0);
        $display("test tick done");
        end_sim();
    end
endmodule : test_audio_fifo_start_and_dma_request
`default_nettype wire
